// File: sapc_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - falling start edge begins a conversion
// - strobes ignored unless device select low
// - result drivers on only with read and select
// - busy low through conversion, high after
// - power down while power_down_n low
// - starts up to 600 kHz supported
// - result latched before busy rises
// - twelve-bit result, bit 11 most significant
// - no restart during a running conversion
// - result loaded into latches at end
module sapc_top
  import sapc_pkg::*;
#(
  parameter int RES_W = RES_BITS
) (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              device_select_n,
  input  wire logic              conversion_start_n,
  input  wire logic              read_strobe_n,
  input  wire logic              power_down_n,
  input  wire logic              comp_high,
  output logic                   sample_hold,
  output logic      [RES_W-1:0]  dac_code,
  output logic                   busy_n,
  output logic      [RES_W-1:0]  result_bits_o,
  output logic      [RES_W-1:0]  result_bits_oe,
  output logic                   powered_down
);

  // ----------------------------------------
  // start edge detection
  // ----------------------------------------
  logic start_q;
  logic start_fall;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      start_q <= 1'b1;
    end else begin
      start_q <= conversion_start_n;
    end
  end
  // an edge only counts while selected and powered up
  assign start_fall = start_q && !conversion_start_n && !device_select_n && power_down_n;

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  sapc_state_t                   state_q;
  logic [CNT_W-1:0]              cnt_q;
  logic [$clog2(RES_W)-1:0]      bit_q;
  logic [RES_W-1:0]              approximation_register_q;
  logic [RES_W-1:0]              latch_q;
  logic [RES_W-1:0]              trial;
  logic [RES_W-1:0]              decided;

  sapc_sar_step #(.W(RES_W)) u_step (
    .cur       (approximation_register_q),
    .bit_idx   (bit_q),
    .comp_high (comp_high),
    .trial     (trial),
    .decided   (decided)
  );

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SAPC_IDLE;
      cnt_q   <= '0;
      bit_q   <= '0;
      approximation_register_q <= '0;
    end else if (!power_down_n) begin
      // power-down abandons any conversion in progress
      state_q <= SAPC_IDLE;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        SAPC_IDLE: begin
          if (start_fall) begin
            state_q <= SAPC_STEP;
            cnt_q   <= '0;
            bit_q   <= ($clog2(RES_W))'(RES_W - 1);
            approximation_register_q <= '0;
          end
        end
        SAPC_STEP: begin
          // further start edges are not looked at here
          if (cnt_q == CNT_W'(STEP_CYCLES - 1)) begin
            cnt_q <= '0;
            approximation_register_q <= decided;
            if (bit_q == '0) begin
              state_q <= SAPC_HOLD;
            end else begin
              bit_q <= bit_q - 1'b1;
            end
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        SAPC_HOLD: begin
          // result sits in the latch before busy is released
          if (cnt_q == CNT_W'(READY_CYCLES - 1)) begin
            state_q <= SAPC_IDLE;
            cnt_q   <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // output latch
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_q <= '0;
    // an aborted conversion must not overwrite the previous result
    end else if (power_down_n && state_q == SAPC_STEP && bit_q == '0 && cnt_q == CNT_W'(STEP_CYCLES - 1)) begin
      latch_q <= decided;
    end
  end

  assign busy_n       = (state_q == SAPC_IDLE);
  assign sample_hold  = (state_q != SAPC_IDLE);
  assign dac_code     = (state_q == SAPC_STEP) ? trial : approximation_register_q;
  assign powered_down = !power_down_n;

  // ----------------------------------------
  // three-state result drivers
  // ----------------------------------------
  // a read during the bit steps of a conversion shows the previous result
  assign result_bits_o = latch_q;
  genvar gi;
  for (gi = 0; gi < RES_W; gi++) begin : g_oe
    assign result_bits_oe[gi] = !read_strobe_n && !device_select_n;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  localparam int BUSY_CYCLES = STEP_CYCLES * RES_W + READY_CYCLES;
  logic [CNT_W-1:0] busy_len_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_len_q <= '0;
    end else begin
      busy_len_q <= busy_n ? '0 : busy_len_q + 1'b1;
    end
  end

  // ----------------------------------------
  // decision bookkeeping for the checks
  // ----------------------------------------
  // counts bit decisions so a lost or doubled step shows up at the load
  logic [$clog2(RES_W+1)-1:0] decisions_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      decisions_q <= '0;
    end else if (busy_n) begin
      decisions_q <= '0;
    end else if (state_q == SAPC_STEP && cnt_q == CNT_W'(STEP_CYCLES - 1)) begin
      decisions_q <= decisions_q + 1'b1;
    end
  end

  chk_start_busy: assert property (@(posedge core_clk) disable iff (!rst_b)
    (busy_n && start_fall) |=> !busy_n) else $error("start edge did not lower busy");
  chk_unselected_start: assert property (@(posedge core_clk) disable iff (!rst_b)
    (busy_n && device_select_n) |=> busy_n) else $error("unselected start accepted");

  chk_drive_enable: assert property (@(posedge core_clk) disable iff (!rst_b)
    (result_bits_oe != '0) |-> (!read_strobe_n && !device_select_n)) else $error("driving while not read");
  chk_drive_on: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!read_strobe_n && !device_select_n) |-> (result_bits_oe == '1))
    else $error("not driving during read");
  chk_float_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
    (read_strobe_n || device_select_n) |-> (result_bits_oe == '0)) else $error("not floating");

  // the count has already taken the last low cycle when busy is first seen high
  chk_busy_length: assert property (@(posedge core_clk) disable iff (!rst_b)
    ($rose(busy_n) && power_down_n && $past(power_down_n))
      |-> (busy_len_q == CNT_W'(BUSY_CYCLES) && $past(busy_len_q) == CNT_W'(BUSY_CYCLES - 1)))
    else $error("busy length wrong");
  chk_pd_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
    !power_down_n |=> busy_n) else $error("conversion during power-down");
  chk_pd_abort: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!power_down_n && !busy_n) |=> (busy_n && $stable(latch_q)))
    else $error("aborted conversion touched result");

  // a restart would put the bit pointer back to the top
  chk_no_restart: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!busy_n && !$past(busy_n)) |-> (bit_q <= $past(bit_q)))
    else $error("conversion restarted");
  // the repetition count is the ready lead in cycles
  chk_ready_lead: assert property (@(posedge core_clk) disable iff (!rst_b)
    $changed(latch_q) |-> !busy_n [*5])
    else $error("result late before busy");

  chk_latch_load: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == SAPC_HOLD && $past(state_q) == SAPC_STEP) |-> (latch_q == approximation_register_q))
    else $error("latch not loaded");
  chk_latch_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == SAPC_STEP && $past(state_q) == SAPC_STEP) |-> $stable(latch_q))
    else $error("result changed mid conversion");
  chk_twelve_steps: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == SAPC_HOLD && $past(state_q) == SAPC_STEP) |-> (decisions_q == ($clog2(RES_W+1))'(RES_W)))
    else $error("wrong number of bit decisions");

  chk_first_trial: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(busy_n) |-> (dac_code == {1'b1, {(RES_W-1){1'b0}}}))
    else $error("first trial is not the top bit");
  chk_bit_order: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == SAPC_STEP && $past(state_q) == SAPC_STEP && bit_q != $past(bit_q)) |-> (bit_q == $past(bit_q) - 1'b1))
    else $error("bits not walked downwards");

  // the busy window must fit the conversion time, or the top start rate is lost
  chk_rate: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(busy_n) |-> (busy_len_q <= CNT_W'(CONV_CYCLES)))
    else $error("too slow for rate");

endmodule : sapc_top

// File: sapc_pkg.sv
package sapc_pkg;

  // ----------------------------------------
  // data path
  // ----------------------------------------
  localparam int RES_BITS = 12;

  // ----------------------------------------
  // timing at a 4 ns clock
  // ----------------------------------------
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int CONV_MAX_PS     = 1600000;
  localparam int THRU_MAX_PS     = 1660000;
  localparam int WAKE_TYP_PS     = 350000;
  localparam int READY_LEAD_PS   = 20000;
  localparam int SAMPLE_MAX_KHZ  = 600;
  // longest time rounds down
  localparam int CONV_CYCLES     = CONV_MAX_PS / CLK_PERIOD_PS;
  // least time rounds up
  localparam int READY_CYCLES    = (READY_LEAD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STEP_CYCLES     = (CONV_CYCLES - READY_CYCLES) / RES_BITS;
  localparam int WAKE_CYCLES     = (WAKE_TYP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W           = 10;

  typedef enum logic [1:0] {
    SAPC_IDLE,
    SAPC_STEP,
    SAPC_HOLD
  } sapc_state_t;

endpackage : sapc_pkg

// File: sapc_sar_step.sv
`timescale 1ns/100ps
// ----------------------------------------
// one bit trial of the approximation register
// ----------------------------------------
module sapc_sar_step #(
  parameter int W = 12
) (
  input  wire logic [W-1:0]        cur,
  input  wire logic [$clog2(W)-1:0] bit_idx,
  input  wire logic                comp_high,
  output logic      [W-1:0]        trial,
  output logic      [W-1:0]        decided
);
  always_comb begin
    trial          = cur;
    trial[bit_idx] = 1'b1;
    decided        = cur;
    // the comparator says whether the trial weight stays
    decided[bit_idx] = comp_high;
  end
endmodule : sapc_sar_step

// File: sapc_far_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// comparator front and data bus wire
// ----------------------------------------
module sapc_far_model
  import sapc_pkg::*;
(
  input  wire logic [RES_BITS-1:0] dac_code,
  input  wire logic [RES_BITS-1:0] level,
  input  wire logic [RES_BITS-1:0] drv,
  input  wire logic [RES_BITS-1:0] oe,
  output logic                     comp_high,
  output logic      [RES_BITS-1:0] bus
);
  logic [RES_BITS-1:0] last_q = '0;
  // keeping a trial bit only at or below the level makes the result equal the level
  assign comp_high = (dac_code <= level);
  always @(drv or oe) if (&oe) last_q = drv;
  // a released line shows the inverse of its last value, never a stale match
  always_comb for (int i = 0; i < RES_BITS; i++) bus[i] = oe[i] ? drv[i] : ~last_q[i];
endmodule : sapc_far_model

// File: sapc_top_bench.sv
`timescale 1ns/100ps
module sapc_top_bench;
  import sapc_pkg::*;
  localparam int CONV = 12 * STEP_CYCLES + READY_CYCLES;
  logic                core_clk, rst_b, sel_n, go_n, rd_n, pd_n, comp, sh, busy_n, pwd;
  logic [RES_BITS-1:0] level, dac, drv, oe, bus;
  int                  bad_count, checks_done, cyc, low_cnt, a0;
  logic [RES_BITS-1:0] rows [4] = '{12'h000, 12'hfff, 12'h800, 12'h5a3};

  sapc_top DUT (.core_clk(core_clk), .rst_b(rst_b), .device_select_n(sel_n), .conversion_start_n(go_n),
    .read_strobe_n(rd_n), .power_down_n(pd_n), .comp_high(comp), .sample_hold(sh), .dac_code(dac),
    .busy_n(busy_n), .result_bits_o(drv), .result_bits_oe(oe), .powered_down(pwd));
  sapc_far_model far (.dac_code(dac), .level(level), .drv(drv), .oe(oe), .comp_high(comp), .bus(bus));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (busy_n === 1'b0) low_cnt++;
  // ----------------------------------------
  // hang guard
  // ----------------------------------------
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [RES_BITS-1:0] got, input logic [RES_BITS-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // start held low 8 ns, well inside the early-release window
  task automatic start(input logic [RES_BITS-1:0] v);
    @(posedge core_clk);
    level <= v;
    go_n  <= 1'b0;
    repeat (2) @(posedge core_clk);
    go_n  <= 1'b1;
  endtask : start
  task automatic finish_read(input logic [RES_BITS-1:0] v);
    for (int i = 0; i < 1000 && busy_n !== 1'b1; i++) @(posedge core_clk);
    chk(RES_BITS'(low_cnt - a0), RES_BITS'(CONV));
    chk({11'h000, sh}, 12'h000);
    rd_n <= 1'b0;
    @(posedge core_clk);
    #1 chk(bus, v);
    chk(oe, 12'hfff);
    @(posedge core_clk);
    rd_n <= 1'b1;
    @(posedge core_clk);
    #1 chk(oe, 12'h000);
  endtask : finish_read

  initial begin
    {rst_b, sel_n, go_n, rd_n, pd_n, level} = {1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 12'h000};
    repeat (3) @(posedge core_clk);
    chk({10'h000, sh, busy_n}, 12'h001);
    chk(drv, 12'h000);
    rst_b <= 1'b1;
    $display("reset done");
    @(posedge core_clk);
    foreach (rows[i]) begin
      a0 = low_cnt;
      start(rows[i]);
      #1 chk(dac, 12'h800);
      chk({11'h000, sh}, 12'h001);
      finish_read(rows[i]);
      $display("row %0d done", i);
    end
    @(posedge core_clk);
    sel_n <= 1'b1;
    rd_n  <= 1'b0;
    a0 = low_cnt;
    start(12'h123);
    repeat (5) @(posedge core_clk);
    #1 chk(RES_BITS'(low_cnt - a0), 12'h000);
    chk(oe, 12'h000);
    @(posedge core_clk);
    {sel_n, rd_n} <= 2'b01;
    $display("unselected done");
    a0 = low_cnt;
    start(12'h3c3);
    repeat (100) @(posedge core_clk);
    start(12'h3c3);
    finish_read(12'h3c3);
    $display("restart done");
    start(12'h0f0);
    repeat (50) @(posedge core_clk);
    pd_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk({10'h000, pwd, busy_n}, 12'h003);
    @(posedge core_clk);
    pd_n <= 1'b1;
    repeat (WAKE_CYCLES) @(posedge core_clk);
    a0 = low_cnt;
    start(12'h0f0);
    finish_read(12'h0f0);
    $display("power down done");
    summarize();
  end
endmodule : sapc_top_bench
